// [rtl/sfr_pkg.sv]
// Shared types and constants for the serial flash read path
// Assumes one system clock; link pins are sampled, not used as clocks
package sfr_pkg;

   // Command opcodes (arbitrary encodings, one byte each)
   localparam logic [7:0] read_single_cmd = 8'h13;
   localparam logic [7:0] read_fast_single_cmd = 8'h0C;
   localparam logic [7:0] read_fast_single3_cmd = 8'h0B;
   localparam logic [7:0] read_dual_io_cmd = 8'hBC;
   localparam logic [7:0] read_quad_out_cmd = 8'h6C;
   localparam logic [7:0] read_quad_io_sdr_cmd = 8'hEC;
   localparam logic [7:0] continuous_read_sdr_cmd = 8'hEB;
   localparam logic [7:0] read_quad_io_ddr_cmd = 8'hEE;
   localparam logic [7:0] continuous_read_ddr_cmd = 8'hED;
   localparam logic [7:0] read_any_register_cmd = 8'h65;
   localparam logic [7:0] read_unique_id_cmd = 8'h4C;

   // Array and address geometry
   localparam int array_aw = 27;
   localparam logic [5:0] cmd_bits = 6'h08;
   localparam logic [5:0] addr_bits3 = 6'h18;
   localparam logic [5:0] addr_bits4 = 6'h20;
   localparam logic [5:0] mode_bits = 6'h08;

   // Continuous read patterns
   localparam logic [3:0] cont_sdr_nib = 4'hA;
   localparam logic [7:0] cont_ddr_byte = 8'hA5;

   // Training pattern windows
   localparam logic [3:0] sdr_pat_min = 4'h9;
   localparam logic [3:0] sdr_pat_len = 4'h8;
   localparam logic [3:0] ddr_pat_min = 4'h5;
   localparam logic [3:0] ddr_pat_len = 4'h4;

   // Register address map
   localparam logic [31:0] reg_volatile_base = 32'h0080_0000;
   localparam logic [31:0] reg_status_one_addr = 32'h0080_0000;
   localparam logic [31:0] reg_ppa_addr = 32'h0000_0100;
   localparam logic [31:0] reg_dya_addr = 32'h0080_0100;
   localparam logic [31:0] reg_pwd_lo = 32'h0000_0020;
   localparam logic [31:0] reg_pwd_hi = 32'h0000_0027;
   localparam logic [2:0] pwd_mode_code = 3'h3;
   localparam logic [7:0] invalid_byte = 8'hFF;

   typedef enum logic [5:0] {
      st_cmd = 6'h01,
      st_addr = 6'h02,
      st_mode = 6'h04,
      st_lat = 6'h08,
      st_data = 6'h10,
      st_skip = 6'h20
   } sfr_state_e;

   typedef enum logic [2:0] {
      k_plain, k_fast, k_dual, k_qout, k_qsdr, k_qddr, k_reg, k_uid
   } sfr_kind_e;

   typedef struct packed {
      logic sck;
      logic cs_n;
      logic [3:0] dq;
   } sfr_pins_s;

   typedef struct packed {
      sfr_pins_s meta;
      sfr_pins_s sync;
   } sfr_sync_s;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } sfr_dq_s;

   typedef struct packed {
      logic [3:0] lat_nv;
      logic [1:0] lat_v;
      logic [7:0] pattern;
      logic all_quad;
      logic addr4;
      logic [2:0] prot_mode;
      logic busy;
   } sfr_cfg_s;

   typedef struct packed {
      sfr_state_e state;
      sfr_kind_e kind;
      logic sck_p;
      logic alen4;
      logic has_mode;
      logic cont;
      logic [5:0] cnt;
      logic [31:0] sh;
      logic [31:0] addr;
      logic [3:0] lat_cnt;
      logic [3:0] lat_tot;
      logic [7:0] out_sh;
      logic [3:0] out_cnt;
      logic [2:0] uid_idx;
      logic [3:0] dq_out;
      logic [3:0] dq_oe;
   } sfr_st_s;

   localparam sfr_pins_s pins_idle = '{sck: 1'b0, cs_n: 1'b1, dq: 4'h0};
   localparam sfr_st_s st_rst = '{state: st_cmd, kind: k_plain, default: '0};

endpackage

// [rtl/sfr_sync.sv]
// Two-stage synchroniser for the serial link pins
// Assumes pins are asynchronous to clock_i
`timescale 1ns/1ps
module sfr_sync import sfr_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire sfr_pins_s pins_i,
   output sfr_pins_s pins_o
);

   sfr_sync_s st;
   sfr_sync_s next_st;

   // Second stage alone reads the first
   always_comb begin
      next_st.meta = pins_i;
      next_st.sync = st.meta;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st <= '{meta: pins_idle, sync: pins_idle};
      end else begin
         st <= next_st;
      end
   end

   assign pins_o = st.sync;

endmodule

// [rtl/sfr_read.sv]
// Read transaction engine of a serial NOR flash, device side
// Assumes host drives sck and cs_n; array and registers answer combinationally
//
// Overview of operation
// - Unique id read returns 64-bit factory value
// - Sequential array bytes until chip select rises
// - Array address wraps to zero at top
// - Plain read has no latency cycles
// - Fast read latency from nonvolatile field
// - Fast read 3/4-byte, training pattern only when all-quad
// - Fast read mode Axh skips next command
// - Dual read: mode, continuous, no pattern
// - Quad output read with training pattern
// - Quad SDR mode Axh skips next command
// - Quad DDR mode A5h skips next command
// - All-quad SDR continuous with Axh mode
// - All-quad DDR continuous with A5h mode
// - Register read latency by volatility field
// - Register byte repeats while clocking continues
// - Status register readable during busy operation
// - Protection access registers not reachable
// - Password locations invalid in password mode
// - Unassigned register addresses return undefined
// - Each read returns only its source
// - SDR pattern in last eight latency cycles
// - DDR pattern in last four latency cycles
`timescale 1ns/1ps
module sfr_read import sfr_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire sfr_pins_s pins_i,
   input wire sfr_cfg_s cfg_i,
   input wire logic [7:0] mem_data_i,
   input wire logic [7:0] reg_data_i,
   input wire logic [63:0] unique_id_i,
   output sfr_dq_s dq_o,
   output logic [array_aw-1:0] mem_addr_o,
   output logic [31:0] reg_addr_o
);

   sfr_pins_s pins;
   sfr_st_s st;
   sfr_st_s next_st;
   logic rise;
   logic fall;
   logic ddr;
   logic pat_on;
   logic pat_sdr;
   logic pat_ddr;
   logic [2:0] w_in;
   logic [2:0] w_out;
   logic [31:0] sh_n;
   logic [5:0] nc;
   logic [7:0] src_byte;
   logic [7:0] reg_byte;
   logic [7:0] uid_byte;
   logic [array_aw-1:0] addr_inc;
   sfr_dq_s d;

   sfr_sync u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pins_i(pins_i),
      .pins_o(pins)
   );

   function automatic logic [2:0] in_width(sfr_kind_e k, logic q);
      case (k)
         k_dual: return 3'h2;
         k_qsdr, k_qddr: return 3'h4;
         default: return q ? 3'h4 : 3'h1;
      endcase
   endfunction

   function automatic logic [2:0] out_width(sfr_kind_e k, logic q);
      case (k)
         k_dual: return 3'h2;
         k_qout, k_qsdr, k_qddr: return 3'h4;
         default: return q ? 3'h4 : 3'h1;
      endcase
   endfunction

   function automatic logic [31:0] shift_in(logic [31:0] s, logic [2:0] w, logic [3:0] v);
      case (w)
         3'h2: return {s[29:0], v[1:0]};
         3'h4: return {s[27:0], v};
         default: return {s[30:0], v[0]};
      endcase
   endfunction

   // Single lane drives the serial output line only
   function automatic sfr_dq_s drive(logic [2:0] w, logic [7:0] b);
      case (w)
         3'h2: return '{out: {2'h0, b[7:6]}, oe: 4'h3};
         3'h4: return '{out: b[7:4], oe: 4'hF};
         default: return '{out: {2'h0, b[7], 1'b0}, oe: 4'h2};
      endcase
   endfunction

   function automatic logic in_pwd(logic [31:0] a);
      return (a >= reg_pwd_lo) && (a <= reg_pwd_hi);
   endfunction

   function automatic logic [3:0] lat_for(sfr_kind_e k, logic [31:0] a, sfr_cfg_s c);
      case (k)
         k_plain: return 4'h0;
         k_uid: return {2'h0, c.lat_v};
         k_reg: return (a >= reg_volatile_base) ? {2'h0, c.lat_v} : c.lat_nv;
         default: return c.lat_nv;
      endcase
   endfunction

   function automatic sfr_st_s start_lat(sfr_st_s s, logic [3:0] l);
      s.lat_cnt = l;
      s.lat_tot = l;
      s.out_cnt = 4'h0;
      s.state = (l == 4'h0) ? st_data : st_lat;
      return s;
   endfunction

   assign rise = pins.sck & ~st.sck_p;
   assign fall = ~pins.sck & st.sck_p;
   assign ddr = (st.kind == k_qddr);
   assign w_in = (st.state == st_cmd) ? (cfg_i.all_quad ? 3'h4 : 3'h1)
                                      : in_width(st.kind, cfg_i.all_quad);
   assign w_out = out_width(st.kind, cfg_i.all_quad);

   // pattern only for quad array reads
   assign pat_on = (cfg_i.pattern != 8'h00) &&
                   (st.kind inside {k_qout, k_qsdr, k_qddr} ||
                    (cfg_i.all_quad && st.kind inside {k_fast})) &&
                   (st.lat_tot >= (ddr ? ddr_pat_min : sdr_pat_min));
   assign pat_sdr = pat_on && !ddr && (st.lat_cnt <= sdr_pat_len);
   assign pat_ddr = pat_on && ddr && (st.lat_cnt <= ddr_pat_len);

   always_comb begin
      reg_byte = reg_data_i;
      if (st.addr == reg_ppa_addr || st.addr == reg_dya_addr) begin
         reg_byte = invalid_byte;
      end else if (in_pwd(st.addr) && cfg_i.prot_mode == pwd_mode_code) begin
         reg_byte = invalid_byte;
      end else if (cfg_i.busy && st.addr != reg_status_one_addr) begin
         reg_byte = invalid_byte;
      end
   end

   assign uid_byte = unique_id_i[{st.uid_idx, 3'h0} +: 8];

   always_comb begin
      case (st.kind)
         k_reg: src_byte = reg_byte;
         k_uid: src_byte = uid_byte;
         default: src_byte = mem_data_i;
      endcase
   end

   assign addr_inc = st.addr[array_aw-1:0] + array_aw'(1'b1);

   always_comb begin
      next_st = st;
      next_st.sck_p = pins.sck;
      sh_n = shift_in(st.sh, w_in, pins.dq);
      nc = 6'(st.cnt + {3'h0, w_in});
      d = '{out: st.dq_out, oe: st.dq_oe};
      if (pins.cs_n) begin
         next_st.state = st.cont ? st_addr : st_cmd;
         next_st.cnt = 6'h0;
         next_st.out_cnt = 4'h0;
         d = '{out: 4'h0, oe: 4'h0};
      end else begin
         case (st.state)
            st_cmd: begin
               if (rise) begin
                  next_st.sh = sh_n;
                  next_st.cnt = nc;
                  if (nc == cmd_bits) begin
                     next_st.cnt = 6'h0;
                     next_st.state = st_addr;
                     next_st.has_mode = 1'b0;
                     next_st.alen4 = cfg_i.addr4;
                     next_st.uid_idx = 3'h0;
                     case (sh_n[7:0])
                        read_single_cmd: next_st.kind = k_plain;
                        read_fast_single_cmd: begin
                           next_st.kind = k_fast;
                           next_st.alen4 = 1'b1;
                           next_st.has_mode = 1'b1;
                        end
                        read_fast_single3_cmd: begin
                           next_st.kind = k_fast;
                           next_st.alen4 = 1'b0;
                        end
                        read_dual_io_cmd: begin
                           next_st.kind = k_dual;
                           next_st.has_mode = 1'b1;
                        end
                        read_quad_out_cmd: next_st.kind = k_qout;
                        read_quad_io_sdr_cmd, continuous_read_sdr_cmd: begin
                           next_st.kind = k_qsdr;
                           next_st.has_mode = 1'b1;
                        end
                        read_quad_io_ddr_cmd, continuous_read_ddr_cmd: begin
                           next_st.kind = k_qddr;
                           next_st.has_mode = 1'b1;
                        end
                        read_any_register_cmd: begin
                           next_st.kind = k_reg;
                           next_st.alen4 = 1'b1;
                        end
                        read_unique_id_cmd: begin
                           next_st.kind = k_uid;
                           next_st = start_lat(next_st, {2'h0, cfg_i.lat_v});
                        end
                        default: next_st.state = st_skip;
                     endcase
                  end
               end
            end
            st_addr: begin
               // first address edge is a rise
               if (rise || (fall && ddr && st.cnt != 6'h0)) begin
                  next_st.sh = sh_n;
                  next_st.cnt = nc;
                  if (nc == (st.alen4 ? addr_bits4 : addr_bits3)) begin
                     next_st.cnt = 6'h0;
                     next_st.addr = st.alen4 ? sh_n : {8'h00, sh_n[23:0]};
                     if (st.has_mode) begin
                        next_st.state = st_mode;
                     end else begin
                        next_st = start_lat(next_st, lat_for(st.kind, next_st.addr, cfg_i));
                     end
                  end
               end
            end
            st_mode: begin
               if (rise || (fall && ddr)) begin
                  next_st.sh = sh_n;
                  next_st.cnt = nc;
                  if (nc == mode_bits) begin
                     next_st.cnt = 6'h0;
                     next_st.cont = ddr ? (sh_n[7:0] == cont_ddr_byte)
                                        : (sh_n[7:4] == cont_sdr_nib);
                     next_st = start_lat(next_st, lat_for(st.kind, st.addr, cfg_i));
                  end
               end
            end
            st_lat: begin
               if (fall && pat_sdr) begin
                  d = '{out: {4{cfg_i.pattern[3'(st.lat_cnt - 4'h1)]}}, oe: 4'hF};
               end else if (fall && pat_ddr) begin
                  d = '{out: {4{cfg_i.pattern[3'({st.lat_cnt[2:0], 1'b0} - 4'h1)]}},
                        oe: 4'hF};
               end
               if (rise) begin
                  if (pat_ddr) begin
                     d = '{out: {4{cfg_i.pattern[3'({st.lat_cnt[2:0], 1'b0} - 4'h2)]}},
                           oe: 4'hF};
                  end
                  next_st.lat_cnt = st.lat_cnt - 4'h1;
                  if (st.lat_cnt == 4'h1) begin
                     next_st.state = st_data;
                  end
               end
            end
            st_data: begin
               if (fall || (rise && ddr)) begin
                  if (st.out_cnt == 4'h0) begin
                     d = drive(w_out, src_byte);
                     next_st.out_sh = 8'(src_byte << w_out);
                     next_st.out_cnt = 4'(4'h8 - {1'b0, w_out});
                     if (st.kind == k_uid) begin
                        next_st.uid_idx = st.uid_idx + 3'h1;
                     end else if (st.kind != k_reg) begin
                        next_st.addr = 32'(addr_inc);
                     end
                  end else begin
                     d = drive(w_out, st.out_sh);
                     next_st.out_sh = 8'(st.out_sh << w_out);
                     next_st.out_cnt = 4'(st.out_cnt - {1'b0, w_out});
                  end
               end
            end
            default: ;
         endcase
      end
      next_st.dq_out = d.out;
      next_st.dq_oe = d.oe;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st <= st_rst;
      end else begin
         st <= next_st;
      end
   end

   assign dq_o = '{out: st.dq_out, oe: st.dq_oe};
   assign mem_addr_o = st.addr[array_aw-1:0];
   assign reg_addr_o = st.addr;

   a_oe_off_deselect: assert property (@(posedge clock_i) disable iff (rst_i)
      pins.cs_n |=> st.dq_oe == 4'h0)
      else $error("Data lines driven while deselected");

   a_addr_wrap_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state == st_data && st.kind inside {k_plain, k_fast, k_dual, k_qout, k_qsdr, k_qddr}
       && !pins.cs_n && fall && st.out_cnt == 4'h0 && (&st.addr[array_aw-1:0]))
      |=> st.addr == 32'h0)
      else $error("Array address did not wrap to zero");

   a_plain_no_lat: assert property (@(posedge clock_i) disable iff (rst_i)
      st.state == st_lat |-> st.kind != k_plain)
      else $error("Plain read entered latency");

   a_fast_lat_load: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state inside {st_addr, st_mode} && next_st.state == st_lat && st.kind == k_fast
       && !pins.cs_n) |=> st.lat_cnt == $past(cfg_i.lat_nv))
      else $error("Fast read latency not from nonvolatile field");

   a_no_pat_single: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state == st_lat && !cfg_i.all_quad && st.kind inside {k_fast, k_dual})
      |-> st.dq_oe == 4'h0)
      else $error("Training pattern on single or dual read");

   a_cont_sdr_arm: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state == st_mode && next_st.state != st_mode && !pins.cs_n && st.kind != k_qddr)
      |=> st.cont == ($past(sh_n[7:4]) == cont_sdr_nib))
      else $error("SDR continuous flag wrong");

   a_cont_ddr_arm: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state == st_mode && next_st.state != st_mode && !pins.cs_n && st.kind == k_qddr)
      |=> st.cont == ($past(sh_n[7:0]) == cont_ddr_byte))
      else $error("DDR continuous flag wrong");

   a_cont_skip_cmd: assert property (@(posedge clock_i) disable iff (rst_i)
      (pins.cs_n && st.cont) |=> st.state == st_addr ##0 st.cnt == 6'h0)
      else $error("Continuation did not start at address");

   a_reg_addr_hold: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state == st_data && st.kind == k_reg && !pins.cs_n) |=> $stable(st.addr))
      else $error("Register address moved during read");

   a_pwd_invalid: assert property (@(posedge clock_i) disable iff (rst_i)
      (in_pwd(st.addr) && cfg_i.prot_mode == pwd_mode_code) |-> reg_byte == invalid_byte)
      else $error("Password location readable in password mode");

   a_train_sdr: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.state == st_lat && fall && !pins.cs_n && pat_sdr) |=> st.dq_oe == 4'hF)
      else $error("Training pattern missing in SDR window");

endmodule

// [bench/sfr_host.sv]
// Host controller model driving the serial read link
// Assumes the bench resolves each data wire from both drivers
`timescale 1ns/1ps
module sfr_host import sfr_pkg::*; (
   input wire sfr_dq_s dq_i,
   output sfr_pins_s pins_o
);
   int cmd_w = 1;
   logic [7:0] got_v;
   logic got_p;
   event got;
   initial pins_o = pins_idle;
   task automatic tick(input logic [3:0] d, input bit drv, output logic [3:0] q);
      pins_o.sck = 1'b0;
      pins_o.dq = drv ? d : ~pins_o.dq;
      #32 pins_o.sck = 1'b1;
      #32 q = dq_i.out;
   endtask
   task automatic send(input logic [31:0] v, input int n, input int w);
      logic [3:0] q;
      for (int i = n - w; i >= 0; i -= w) begin
         tick(4'(v >> i) & 4'((1 << w) - 1), 1'b1, q);
      end
   endtask
   task automatic recv(input int n, input int w, input bit pat);
      logic [3:0] q;
      logic [7:0] b;
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < (pat ? 1 : 8); i += w) begin
            tick(4'h0, 1'b0, q);
            b = (b << w) | 8'(w == 1 ? {3'h0, q[1]} : w == 2 ? {2'h0, q[1:0]} : q);
         end
         got_v = pat ? {4'h0, q} : b;
         got_p = pat;
         -> got;
      end
   endtask
   task automatic xfer(input logic [7:0] op, input int no, input int an, input int aw,
      input logic [31:0] a, input int mn, input logic [7:0] m, input int lat,
      input int np, input int dw, input int n);
      logic [3:0] q;
      #3.3 pins_o.cs_n = 1'b0;
      send(32'(op), no, cmd_w);
      send(a, an, aw);
      send(32'(m), mn, aw);
      repeat (lat - np) tick(4'h0, 1'b0, q);
      recv(np, 4, 1'b1);
      recv(n, dw, 1'b0);
      #8 pins_o.cs_n = 1'b1;
      pins_o.sck = 1'b0;
      #300;
   endtask
   task automatic post(input logic p, input logic [7:0] v);
      got_v = v;
      got_p = p;
      -> got;
   endtask
   // both edges, output read before each edge
   task automatic dtick(input logic [3:0] d0, input logic [3:0] d1, input int k);
      logic [3:0] q0;
      pins_o.sck = 1'b0;
      pins_o.dq = d0;
      #16 q0 = dq_i.out;
      pins_o.sck = 1'b1;
      if (k == 1) post(1'b1, {4'h0, q0});
      #16 pins_o.dq = d1;
      #16 if (k == 1) post(1'b1, {4'h0, dq_i.out});
      if (k == 2) post(1'b0, {q0, dq_i.out});
      pins_o.sck = 1'b0;
      #16;
   endtask
   task automatic xfer_ddr(input logic [7:0] op, input int no, input logic [31:0] a,
      input logic [7:0] m, input int lat, input int n);
      #3.3 pins_o.cs_n = 1'b0;
      send(32'(op), no, cmd_w);
      for (int i = 28; i >= 0; i -= 8) dtick(4'(a >> i), 4'(a >> (i - 4)), 0);
      dtick(m[7:4], m[3:0], 0);
      repeat (lat - 4) dtick(~pins_o.dq, ~pins_o.dq, 0);
      repeat (4) dtick(~pins_o.dq, ~pins_o.dq, 1);
      repeat (n) dtick(~pins_o.dq, ~pins_o.dq, 2);
      #8 pins_o.cs_n = 1'b1;
      #300;
   endtask
endmodule

// [bench/serial_flash_read_transactions_bench.sv]
// Self-checking bench for the serial flash read path
// Assumes the host model in sfr_host.sv; array and registers answer from functions of the address
`timescale 1ns/1ps
module serial_flash_read_transactions_bench import sfr_pkg::*;;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   sfr_cfg_s cfg = '{lat_nv: 4'h3, lat_v: 2'h2, pattern: 8'hB4, addr4: 1'b1, default: '0};
   sfr_pins_s host_pins;
   sfr_pins_s pins;
   sfr_dq_s dq;
   sfr_dq_s wire_dq;
   logic [array_aw-1:0] mem_addr;
   logic [31:0] reg_addr;
   logic [63:0] uid = 64'h0123_4567_89AB_CDEF;
   logic [8:0] exp_q[$];
   logic [34:0] rt [7] = '{{reg_status_one_addr, 3'b100}, {reg_volatile_base + 32'h4, 3'b101},
      {reg_ppa_addr, 3'b001}, {reg_dya_addr, 3'b001}, {reg_pwd_lo + 32'h3, 3'b011},
      {reg_pwd_hi, 3'b000}, {32'h0000_0004, 3'b000}};
   int n_mismatch = 0;
   int checks = 0;
   integer seed = 32'h6D849D48;
   logic [31:0] a;
   int rl;
   function automatic logic [7:0] mem_f(input logic [array_aw-1:0] x);
      return x[7:0] ^ x[15:8] ^ x[26:19];
   endfunction
   always #4 clock_i = ~clock_i;
   assign pins = '{sck: host_pins.sck, cs_n: host_pins.cs_n,
      dq: (dq.oe & dq.out) | (~dq.oe & host_pins.dq)};
   assign wire_dq = '{out: pins.dq, oe: dq.oe};
   sfr_read dut_u (.clock_i(clock_i), .rst_i(rst_i), .pins_i(pins), .cfg_i(cfg),
      .mem_data_i(mem_f(mem_addr)), .reg_data_i(reg_addr[7:0] ^ 8'hC3),
      .unique_id_i(uid), .dq_o(dq), .mem_addr_o(mem_addr), .reg_addr_o(reg_addr));
   sfr_host host_u (.dq_i(wire_dq), .pins_o(host_pins));
   task automatic sync_edge();
      @(posedge clock_i);
      #1;
   endtask
   task automatic note(input logic p, input logic [7:0] v);
      exp_q.push_back({p, v});
   endtask
   task automatic note_mem(input logic [31:0] x, input int n);
      for (int i = 0; i < n; i++) note(1'b0, mem_f(array_aw'(x + i)));
   endtask
   task automatic note_pat();
      for (int j = 7; j >= 0; j--) note(1'b1, {4'h0, {4{cfg.pattern[j]}}});
   endtask
   task automatic cmp_data(input logic [8:0] e, input logic [7:0] v);
      checks++;
      if (e !== {1'b0, v}) begin
         n_mismatch++;
         $display("mismatch data expected %h seen %h", e, v);
      end
   endtask
   task automatic cmp_pat(input logic [8:0] e, input logic [7:0] v);
      checks++;
      if (e !== {1'b1, v}) begin
         n_mismatch++;
         $display("mismatch pattern expected %h seen %h", e, v);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(host_u.got) begin
      logic [8:0] e;
      e = 'x;
      if (exp_q.size() > 0) e = exp_q.pop_front();
      if (host_u.got_p) cmp_pat(e, host_u.got_v);
      else cmp_data(e, host_u.got_v);
   end
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clock_i);
      #1 rst_i = 1'b0;
      repeat (4) @(posedge clock_i);
      note_mem(32'h07FF_FFFE, 4);
      host_u.xfer(read_single_cmd, 8, 32, 1, 32'h07FF_FFFE, 0, 8'h00, 0, 0, 1, 4);
      sync_edge();
      cfg.lat_nv = 4'(1 + ($random(seed) & 7));
      a = $random(seed) & 32'h07FF_FFFF;
      note_mem(a, 2);
      host_u.xfer(read_fast_single_cmd, 8, 32, 1, a, 8, 8'hA7, cfg.lat_nv, 0, 1, 2);
      note_mem(a ^ 32'h0555_5555, 2);
      host_u.xfer(8'h00, 0, 32, 1, a ^ 32'h0555_5555, 8, 8'h00, cfg.lat_nv, 0, 1, 2);
      note_mem(a + 9, 2);
      host_u.xfer(read_fast_single_cmd, 8, 32, 1, a + 9, 8, 8'h00, cfg.lat_nv, 0, 1, 2);
      note_mem(a & 32'h00FF_FFFF, 2);
      host_u.xfer(read_fast_single3_cmd, 8, 24, 1, a, 0, 8'h00, cfg.lat_nv, 0, 1, 2);
      note_mem(a, 2);
      host_u.xfer(read_dual_io_cmd, 8, 32, 2, a, 8, 8'hA0, cfg.lat_nv, 0, 2, 2);
      note_mem(a + 3, 2);
      host_u.xfer(8'h00, 0, 32, 2, a + 3, 8, 8'h00, cfg.lat_nv, 0, 2, 2);
      sync_edge();
      cfg.lat_nv = 4'hA;
      note_pat();
      note_mem(a, 2);
      host_u.xfer(read_quad_out_cmd, 8, 32, 1, a, 0, 8'h00, 10, 8, 4, 2);
      for (int q = 0; q < 2; q++) begin
         sync_edge();
         cfg.lat_nv = 4'h9;
         cfg.all_quad = q[0];
         host_u.cmd_w = q ? 4 : 1;
         note_pat();
         note_mem(a, 2);
         host_u.xfer(q ? continuous_read_sdr_cmd : read_quad_io_sdr_cmd, 8, 32, 4, a, 8,
            8'hA5, 9, 8, 4, 2);
         note_pat();
         note_mem(a + 5, 2);
         host_u.xfer(8'h00, 0, 32, 4, a + 5, 8, 8'h00, 9, 8, 4, 2);
         sync_edge();
         cfg.lat_nv = 4'h5;
         note_pat();
         note_mem(a, 2);
         host_u.xfer_ddr(q ? continuous_read_ddr_cmd : read_quad_io_ddr_cmd, 8, a, 8'hA5, 5, 2);
         note_pat();
         note_mem(a + 7, 2);
         host_u.xfer_ddr(8'h00, 0, a + 7, 8'h00, 5, 2);
      end
      sync_edge();
      cfg.all_quad = 1'b0;
      host_u.cmd_w = 1;
      foreach (rt[i]) begin
         sync_edge();
         cfg.busy = rt[i][2];
         cfg.prot_mode = rt[i][1] ? pwd_mode_code : 3'h0;
         a = rt[i][34:3];
         rl = a >= reg_volatile_base ? cfg.lat_v : cfg.lat_nv;
         repeat (2) note(1'b0, rt[i][0] ? invalid_byte : a[7:0] ^ 8'hC3);
         host_u.xfer(read_any_register_cmd, 8, 32, 1, a, 0, 8'h00, rl, 0, 1, 2);
      end
      for (int i = 0; i < 9; i++) note(1'b0, uid[8 * (i % 8) +: 8]);
      host_u.xfer(read_unique_id_cmd, 8, 0, 1, 32'h0, 0, 8'h00, cfg.lat_v, 0, 1, 9);
      repeat (20) @(posedge clock_i);
      if (exp_q.size() != 0) n_mismatch++;
      give_verdict();
   end
endmodule
